// *** hw/dacc_params.svh ***
// dacc_params.svh: register offsets, field positions, mode codes and
// reset values of the dual action capture/compare unit.
// assumes: included by bare name from every file that needs a constant.
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH

// ==========================================================
// register word index, taken from byte address bits [3:2]
`define DACC_IDX_CTRL 2'h0
`define DACC_IDX_DATA_A 2'h1
`define DACC_IDX_DATA_B 2'h2
`define DACC_IDX_COH 2'h3
`define DACC_IDX_HI 3
`define DACC_IDX_LO 2

// ==========================================================
// unit_status_control_reg field positions
`define DACC_F_FLAG 15
`define DACC_F_IL_HI 14
`define DACC_F_IL_LO 12
`define DACC_F_IEN 10
`define DACC_F_BSL 8
`define DACC_F_IN 7
`define DACC_F_EDGE_POLARITY_SELECT 4
`define DACC_F_MODE_HI 3
`define DACC_F_MODE_LO 0
`define DACC_F_PWM_RES_HI 2

// ==========================================================
// mode codes; any code with bit 3 set is continuous_pwm_mode
`define DACC_MODE_OFF 4'h0
`define DACC_MODE_PULSE 4'h1
`define DACC_MODE_PERIOD 4'h2
`define DACC_MODE_SINGLE 4'h3
`define DACC_MODE_CMP_SECOND 4'h4
`define DACC_MODE_CMP_BOTH 4'h5
`define DACC_MODE_PWM_BIT 3

// ==========================================================
// reset values
`define DACC_RST_WORD 16'h0000
`define DACC_RST_BUS 32'h0000_0000
`define DACC_RST_IL 3'h0
`define DACC_RST_MODE 4'h0

`endif

// *** hw/dacc_pkg.sv ***
// dacc_pkg: shared types of the dual action capture/compare unit.
// assumes: compiled before every design file.
package dacc_pkg;

   // ==========================================================
   // types
   typedef logic [15:0] dacc_word_t;

   typedef enum logic [1:0] {
      DACC_BUS_IDLE,
      DACC_BUS_COH,
      DACC_BUS_ACK
   } dacc_bus_st_t;

endpackage

// *** hw/dacc_pin_filter.sv ***
// dacc_pin_filter: two-flop synchroniser followed by a hysteresis stage
// for the unit's input pin.
// assumes: pin_i may change at any time relative to mclk_i.
`timescale 1ns/1ps
module dacc_pin_filter
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o
);

   logic meta_r;
   logic sync_r;
   logic hold_r;
   logic level_r;

   // ==========================================================
   // synchroniser; meta_r feeds sync_r only
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         hold_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         hold_r <= sync_r;
      end
   end

   // hysteresis: the level moves only after two equal samples,
   // so a one-cycle glitch never reaches the edge detector
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         level_r <= 1'b0;
      else if (sync_r == hold_r)
         level_r <= hold_r;
   end

   assign level_o = level_r;

endmodule

// *** hw/dacc_unit.sv ***
// dacc_unit: dual action capture/compare unit with an Avalon-MM slave.
// assumes: time base buses are synchronous to mclk_i; the pin drives
// through pin_o/pin_oe_o and is sampled through dacc_pin_filter.
`timescale 1ns/1ps
`include "dacc_params.svh"
module dacc_unit
   import dacc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [15:0] tbus_a_i,
   input wire logic [15:0] tbus_b_i,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic irq_o
);

   // ==========================================================
   // functions

   // byte-lane merge of a 16-bit write into an old value
   function automatic dacc_word_t merge_be(dacc_word_t old_v,
      dacc_word_t new_v, logic [1:0] be);
      dacc_word_t res;
      res = old_v;
      if (be[0])
         res[7:0] = new_v[7:0];
      if (be[1])
         res[15:8] = new_v[15:8];
      return res;
   endfunction

   // pwm count mask from the low three mode bits
   function automatic dacc_word_t res_mask(logic [2:0] sel);
      dacc_word_t m;
      unique case (sel)
         3'h0: m = 16'h007F;
         3'h1: m = 16'h01FF;
         3'h2: m = 16'h07FF;
         3'h3: m = 16'h0FFF;
         3'h4: m = 16'h1FFF;
         3'h5: m = 16'h3FFF;
         3'h6: m = 16'h7FFF;
         3'h7: m = 16'hFFFF;
      endcase
      return m;
   endfunction

   // ==========================================================
   // state
   dacc_bus_st_t st_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic coh_r;
   logic flag_r;
   logic [2:0] il_r;
   logic ien_r;
   logic bsl_r;
   logic edge_polarity_select_r;
   logic [3:0] mode_r;
   dacc_word_t a_r;
   dacc_word_t b1_r;
   dacc_word_t b2_r;
   dacc_word_t pend_val_r;
   logic pend_x_r;
   logic pend_flag_r;
   logic lead_seen_r;
   logic first_r;
   logic arm_a_r;
   logic arm_b_r;
   logic out_ff_r;
   logic oe_r;
   logic lvl_d_r;
   logic irq_r;

   // ==========================================================
   // decode
   logic [1:0] idx;
   logic wr_go;
   logic is_off;
   logic is_pwm;
   logic is_cmp;
   logic is_coh_mode;
   logic lvl;
   dacc_word_t tb;
   dacc_word_t b_vis;
   dacc_word_t rd_ctrl;
   logic [31:0] rd_word;

   assign idx = avs_address_i[`DACC_IDX_HI:`DACC_IDX_LO];
   // writes land on the edge where waitrequest is seen low
   assign wr_go = (st_r == DACC_BUS_ACK) && avs_write_i;
   assign is_off = (mode_r == `DACC_MODE_OFF);
   assign is_pwm = mode_r[`DACC_MODE_PWM_BIT];
   assign is_cmp = (mode_r == `DACC_MODE_CMP_SECOND) ||
                   (mode_r == `DACC_MODE_CMP_BOTH);
   assign is_coh_mode = (mode_r == `DACC_MODE_PULSE) ||
                        (mode_r == `DACC_MODE_PERIOD);
   assign tb = bsl_r ? tbus_b_i : tbus_a_i;
   assign b_vis = is_pwm ? b1_r : b2_r;

   // ==========================================================
   // pin input
   dacc_pin_filter u_pin_filter
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(pin_i),
      .level_o(lvl)
   );

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lvl_d_r <= 1'b0;
      else
         lvl_d_r <= lvl;
   end

   logic rise;
   logic fall;
   logic sel_edge;
   logic opp_edge;
   assign rise = lvl && !lvl_d_r;
   assign fall = !lvl && lvl_d_r;
   assign sel_edge = edge_polarity_select_r ? rise : fall;
   assign opp_edge = edge_polarity_select_r ? fall : rise;

   // ==========================================================
   // capture events
   logic cap_a;
   logic cap_b1;
   logic xfer;
   logic flag_cap;

   always_comb
   begin
      cap_a = 1'b0;
      cap_b1 = 1'b0;
      xfer = 1'b0;
      flag_cap = 1'b0;
      if (mode_r == `DACC_MODE_PULSE)
      begin
         // leading edge to stage one, trailing edge to A
         cap_b1 = sel_edge;
         if (opp_edge && lead_seen_r)
         begin
            cap_a = 1'b1;
            xfer = 1'b1;
            flag_cap = 1'b1;
         end
      end
      else if ((mode_r == `DACC_MODE_PERIOD) ||
               (mode_r == `DACC_MODE_SINGLE))
      begin
         cap_a = sel_edge;
         cap_b1 = sel_edge;
         xfer = sel_edge;
         flag_cap = sel_edge &&
            ((mode_r == `DACC_MODE_SINGLE) || !first_r);
      end
   end

   // ==========================================================
   // compare events
   dacc_word_t mask;
   logic a_hit;
   logic b_hit;
   logic pa_hit;
   logic pb_hit;
   logic p_start;
   logic set_hit;
   logic clr_hit;
   logic flag_cmp;

   assign mask = res_mask(mode_r[`DACC_F_PWM_RES_HI:`DACC_F_MODE_LO]);
   assign a_hit = is_cmp && arm_a_r && (tb == a_r);
   assign b_hit = is_cmp && arm_b_r && (tb == b2_r);
   assign pa_hit = is_pwm && ((tb & mask) == (a_r & mask));
   assign pb_hit = is_pwm && ((tb & mask) == (b2_r & mask));
   assign p_start = is_pwm && ((tb & mask) == `DACC_RST_WORD);
   assign set_hit = a_hit || pa_hit;
   assign clr_hit = b_hit || pb_hit;
   // single-shot flags on B, or on either in the both-channel code
   assign flag_cmp = b_hit ||
      (a_hit && (mode_r == `DACC_MODE_CMP_BOTH)) || p_start;

   logic flag_evt;
   assign flag_evt = flag_cap || flag_cmp;

   // ==========================================================
   // bus slave: idle, optional second beat, one-cycle answer
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r <= DACC_BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= `DACC_RST_BUS;
         coh_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            DACC_BUS_IDLE:
               if (avs_read_i || avs_write_i)
               begin
                  if ((idx == `DACC_IDX_COH) && is_coh_mode)
                  begin
                     // A now, B one cycle later under deferral
                     st_r <= DACC_BUS_COH;
                     coh_r <= 1'b1;
                     rdata_r[31:16] <= a_r;
                  end
                  else
                  begin
                     st_r <= DACC_BUS_ACK;
                     wait_r <= 1'b0;
                     rdata_r <= rd_word;
                  end
               end
            DACC_BUS_COH:
            begin
               st_r <= DACC_BUS_ACK;
               wait_r <= 1'b0;
               rdata_r[15:0] <= b_vis;
            end
            DACC_BUS_ACK:
            begin
               st_r <= DACC_BUS_IDLE;
               wait_r <= 1'b1;
               coh_r <= 1'b0;
            end
         endcase
      end
   end

   // read mux; the pin level bit follows the mode
   always_comb
   begin
      rd_ctrl = `DACC_RST_WORD;
      rd_ctrl[`DACC_F_FLAG] = flag_r;
      rd_ctrl[`DACC_F_IL_HI:`DACC_F_IL_LO] = il_r;
      rd_ctrl[`DACC_F_IEN] = ien_r;
      rd_ctrl[`DACC_F_BSL] = bsl_r;
      rd_ctrl[`DACC_F_IN] = (is_cmp || is_pwm) ? out_ff_r : lvl;
      rd_ctrl[`DACC_F_EDGE_POLARITY_SELECT] = edge_polarity_select_r;
      rd_ctrl[`DACC_F_MODE_HI:`DACC_F_MODE_LO] = mode_r;
      unique case (idx)
         `DACC_IDX_CTRL: rd_word = {`DACC_RST_WORD, rd_ctrl};
         `DACC_IDX_DATA_A: rd_word = {`DACC_RST_WORD, a_r};
         `DACC_IDX_DATA_B: rd_word = {`DACC_RST_WORD, b_vis};
         `DACC_IDX_COH: rd_word = {a_r, b_vis};
      endcase
   end

   // ==========================================================
   // control register writes
   logic wr_ctrl;
   assign wr_ctrl = wr_go && (idx == `DACC_IDX_CTRL);

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         il_r <= `DACC_RST_IL;
         ien_r <= 1'b0;
         bsl_r <= 1'b0;
         edge_polarity_select_r <= 1'b0;
         mode_r <= `DACC_RST_MODE;
      end
      else if (wr_ctrl)
      begin
         if (avs_byteenable_i[1])
         begin
            il_r <= avs_writedata_i[`DACC_F_IL_HI:`DACC_F_IL_LO];
            ien_r <= avs_writedata_i[`DACC_F_IEN];
            bsl_r <= avs_writedata_i[`DACC_F_BSL];
         end
         if (avs_byteenable_i[0])
         begin
            edge_polarity_select_r <= avs_writedata_i[`DACC_F_EDGE_POLARITY_SELECT];
            mode_r <= avs_writedata_i[`DACC_F_MODE_HI:`DACC_F_MODE_LO];
         end
      end
   end

   // ==========================================================
   // event flag; a set in the clearing cycle wins over the clear
   logic flag_clr;
   logic flag_set;
   assign flag_clr = wr_ctrl && avs_byteenable_i[1] &&
                     !avs_writedata_i[`DACC_F_FLAG];
   assign flag_set = !coh_r && (flag_evt || pend_flag_r);

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flag_r <= 1'b0;
      else if (is_off)
         flag_r <= 1'b0;
      else if (flag_set)
         flag_r <= 1'b1;
      else if (flag_clr)
         flag_r <= 1'b0;
   end

   // deferred flag and stage two transfer while coherent access runs
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pend_flag_r <= 1'b0;
         pend_x_r <= 1'b0;
         pend_val_r <= `DACC_RST_WORD;
      end
      else if (is_off || !coh_r)
      begin
         pend_flag_r <= 1'b0;
         pend_x_r <= 1'b0;
      end
      else
      begin
         if (flag_evt)
            pend_flag_r <= 1'b1;
         if (xfer)
         begin
            pend_x_r <= 1'b1;
            pend_val_r <= b1_r; // old stage one, before recapture
         end
      end
   end

   // ==========================================================
   // data registers; a capture beats a software write in one cycle
   logic wr_a;
   logic wr_b;
   logic wr_coh;
   dacc_word_t a_wval;
   dacc_word_t b_wval;
   assign wr_coh = wr_go && (idx == `DACC_IDX_COH);
   assign wr_a = wr_go && ((idx == `DACC_IDX_DATA_A) || wr_coh);
   assign wr_b = wr_go && ((idx == `DACC_IDX_DATA_B) || wr_coh);
   assign a_wval = wr_coh ?
      merge_be(a_r, avs_writedata_i[31:16], avs_byteenable_i[3:2]) :
      merge_be(a_r, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
   assign b_wval = merge_be(b_vis, avs_writedata_i[15:0],
                            avs_byteenable_i[1:0]);

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         a_r <= `DACC_RST_WORD;
         b1_r <= `DACC_RST_WORD;
         b2_r <= `DACC_RST_WORD;
      end
      else
      begin
         if (wr_a)
            a_r <= a_wval;
         if (wr_b && (is_off || is_pwm))
            b1_r <= b_wval;
         if (wr_b && !is_pwm)
            b2_r <= b_wval;
         if (cap_a)
            a_r <= tb;
         if (cap_b1)
            b1_r <= tb;
         // stage two follows stage one with no lost count
         if (xfer && !coh_r)
            b2_r <= b1_r;
         else if (pend_x_r && !coh_r)
            b2_r <= pend_val_r;
         else if (p_start)
            b2_r <= b1_r;
      end
   end

   // ==========================================================
   // capture sequencing, restarted by off mode
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lead_seen_r <= 1'b0;
         first_r <= 1'b1;
      end
      else if (is_off)
      begin
         lead_seen_r <= 1'b0;
         first_r <= 1'b1;
      end
      else
      begin
         if ((mode_r == `DACC_MODE_PULSE) && sel_edge)
            lead_seen_r <= 1'b1;
         if (cap_a)
            first_r <= 1'b0;
      end
   end

   // comparator arming; a write re-arms even in its match cycle
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         arm_a_r <= 1'b0;
         arm_b_r <= 1'b0;
      end
      else if (!is_cmp)
      begin
         arm_a_r <= 1'b0;
         arm_b_r <= 1'b0;
      end
      else
      begin
         if (wr_a)
            arm_a_r <= 1'b1;
         else if (a_hit)
            arm_a_r <= 1'b0;
         if (wr_b)
            arm_b_r <= 1'b1;
         else if (b_hit)
            arm_b_r <= 1'b0;
      end
   end

   // ==========================================================
   // output flip-flop; polarity bit gives the active level
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         out_ff_r <= 1'b0;
      else if (is_off)
         out_ff_r <= !edge_polarity_select_r;
      else if (clr_hit)
         out_ff_r <= !edge_polarity_select_r; // equal values give no pulse
      else if (set_hit)
         out_ff_r <= edge_polarity_select_r;
   end

   // pin drives only in output modes; off leaves it as an input
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         oe_r <= 1'b0;
      else
         oe_r <= is_cmp || is_pwm;
   end

   // ==========================================================
   // interrupt request
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_r <= 1'b0;
      else
         irq_r <= flag_r && ien_r && (il_r != `DACC_RST_IL);
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign pin_o = out_ff_r;
   assign pin_oe_o = oe_r;
   assign irq_o = irq_r;

endmodule

// *** tb/dacc_far_model.sv ***
// dacc_far_model.sv: far side of the unit, its pin driver and two
// time base buses.
// assumes: the bench steers it through its tasks; changes follow edges.
`timescale 1ns/1ps
module dacc_far_model
(
   input wire logic mclk_i,
   input wire logic pin_o,
   input wire logic pin_oe_o,
   output logic pin_i,
   output logic [15:0] tbus_a_o,
   output logic [15:0] tbus_b_o
);
   logic drv_r;
   // ==========================================================
   // start values, so the unit never sees an unknown level
   initial
   begin
      drv_r = 1'b0;
      tbus_a_o = 16'h0000;
      tbus_b_o = 16'h0000;
   end
   // wire level: the unit wins while it drives, our driver otherwise
   assign pin_i = pin_oe_o ? pin_o : drv_r;
   // levels are held for many cycles, so the filter never drops them
   task automatic set_pin(input logic v);
      @(posedge mclk_i);
      drv_r <= v;
   endtask
   // bases hold still so a capture has one expected value
   task automatic set_base(input logic [15:0] a, input logic [15:0] b);
      @(posedge mclk_i);
      tbus_a_o <= a;
      tbus_b_o <= b;
   endtask
endmodule

// *** tb/dacc_unit_asserts.sv ***
// dacc_unit_asserts.sv: timing and value checks at the unit's ports.
// assumes: bound into dacc_unit; one clock, async low reset.
`timescale 1ns/1ps
module dacc_unit_asserts
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [15:0] tbus_a_i,
   input wire logic [15:0] tbus_b_i,
   input wire logic pin_i,
   input wire logic pin_o,
   input wire logic pin_oe_o,
   input wire logic irq_o
);
   logic [15:0] ctl_r;
   logic hit, mz, outm, coh, ans;
   // ==========================================================
   // shadow of the control word; assumes full-word writes
   assign hit = avs_write_i & !avs_waitrequest_o & avs_address_i[3:2] == 2'h0;
   assign ans = avs_read_i & !avs_waitrequest_o & avs_address_i[3:2] == 2'h0;
   assign mz = ctl_r[3:0] == 4'h0;
   assign outm = ctl_r[3] | ctl_r[3:1] == 3'h2;
   assign coh = avs_address_i[3:2] == 2'h3 & ctl_r[3:2] == 2'h0 & ^ctl_r[1:0];
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ctl_r <= 16'h0000;
      else if (hit)
         ctl_r <= avs_writedata_i[15:0];
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // bus answers
   ans_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   ans_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i | avs_write_i))
      else $error("answer without a request");
   ans_fast_a: assert property (($rose(avs_read_i) || $rose(avs_write_i)) && !coh
      |=> !avs_waitrequest_o)
      else $error("plain access not answered in one cycle");
   coh_two_a: assert property ($rose(avs_read_i) && coh
      |=> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("coherent access not answered in two cycles");
   // ==========================================================
   // control readback and pin
   ctl_echo_a: assert property (ans |-> (avs_readdata_o[15:0] & 16'h751F)
      == (ctl_r & 16'h751F))
      else $error("control fields do not read back");
   ctl_rsv_a: assert property (ans |-> avs_readdata_o[31:16] == 16'h0000
      && avs_readdata_o[11] == 1'b0 && avs_readdata_o[6:5] == 2'h0)
      else $error("reserved control bits not zero");
   flag_off_a: assert property (ans && mz && $past(mz) && $past(mz, 2)
      |-> avs_readdata_o[15] == 1'b0)
      else $error("flag set in off mode");
   oe_mode_a: assert property (ctl_r == $past(ctl_r, 2) |-> pin_oe_o == outm)
      else $error("pin drive does not follow mode");
   in_ff_a: assert property (ans && pin_oe_o && $past(pin_oe_o, 2)
      && pin_o == $past(pin_o) && pin_o == $past(pin_o, 2)
      |-> avs_readdata_o[7] == pin_o)
      else $error("level bit differs from output flip-flop");
   irq_cause_a: assert property (irq_o |-> $past(ctl_r[10] && ctl_r[14:12] != 3'h0))
      else $error("request without enable and level");
   irq_off_a: assert property (mz && $past(mz) && $past(mz, 2) && $past(mz, 3)
      |-> !irq_o)
      else $error("request while unit is off");
endmodule
bind dacc_unit dacc_unit_asserts u_chk
(
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .tbus_a_i(tbus_a_i), .tbus_b_i(tbus_b_i), .pin_i(pin_i), .pin_o(pin_o),
   .pin_oe_o(pin_oe_o), .irq_o(irq_o)
);

// *** tb/dacc_unit_tb_top.sv ***
// dacc_unit_tb_top.sv: register-level tests of the capture/compare unit.
// assumes: dacc_far_model drives pin and bases; the checker is bound.
`timescale 1ns/1ps
module dacc_unit_tb_top
   import dacc_pkg::*;
;
   logic mclk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [3:0] avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic pin_i, pin_o, pin_oe_o, irq_o;
   logic [15:0] tbus_a_i, tbus_b_i;
   int miscompares = 0;
   int num_checks = 0;
   int rw[8] = '{7, 9, 11, 12, 13, 14, 15, 16};
   dacc_unit dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .tbus_a_i(tbus_a_i),
      .tbus_b_i(tbus_b_i), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .irq_o(irq_o));
   dacc_far_model u_far (.mclk_i(mclk_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .pin_i(pin_i), .tbus_a_o(tbus_a_i),
      .tbus_b_o(tbus_b_i));
   // ==========================================================
   // clock, verdict and bus tasks
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic summarize();
      if (miscompares == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // request held until waitrequest is seen low; bounded wait
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         miscompares++;
         summarize();
      end
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wrw(input logic [3:0] a, input logic [15:0] d);
      acc(1'b1, a, {16'h0000, d});
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // outputs are looked at mid-cycle, after the edge has settled
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   task automatic pin(input logic v);
      u_far.set_pin(v);
      settle(10);
   endtask
   function automatic logic [15:0] ctl(input logic [2:0] il,
      input logic ien, time_base_select, pol, input logic [3:0] m);
      return {1'b0, il, 1'b0, ien, 1'b0, time_base_select, 3'h0, pol, m};
   endfunction
   // off first, new mode with requests masked, clear, then unmask
   task automatic mode_to(input logic [15:0] c);
      wrw(4'h0, c & 16'h0110);
      wrw(4'h0, c & 16'hFBFF);
      wrw(4'h0, c & 16'hFBFF);
      wrw(4'h0, c);
   endtask
   // ==========================================================
   // watchdog far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      miscompares++;
      summarize();
   end
   // ==========================================================
   // test sequence
   initial
   begin
      rst_n_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hF;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdc("ctrl", 4'h0, 32'h0);
      rdc("data_a", 4'h4, 32'h0);
      wrw(4'h4, 16'h1234);
      wrw(4'h8, 16'hABCD);
      rdc("data_a", 4'h4, 32'h1234);
      rdc("coh", 4'hC, 32'h1234ABCD);
      pin(1'b1);
      rdc("ctrl_in", 4'h0, 32'h80);
      for (int b = 0; b < 2; b++)
      begin
         pin(1'b0);
         mode_to(ctl(3'h2, 1'b0, b[0], 1'b1, 4'h3));
         u_far.set_base(16'h0A51, 16'hB0C3);
         pin(1'b1);
         rdc("cap_a", 4'h4, b ? 32'hB0C3 : 32'h0A51);
         rdc("flag", 4'h0, {16'h0, ctl(3'h2, 1'b0, b[0], 1'b1, 4'h3) | 16'h8080});
         chk("irq_mask", 32'h0, {31'h0, irq_o});
         wrw(4'h0, ctl(3'h2, 1'b1, b[0], 1'b1, 4'h3) | 16'h8000);
         settle(2);
         chk("irq_on", 32'h1, {31'h0, irq_o});
         u_far.set_base(16'h0777, 16'h0777);
         pin(1'b0);
         rdc("no_fall", 4'h4, b ? 32'hB0C3 : 32'h0A51);
         wrw(4'h0, ctl(3'h2, 1'b1, b[0], 1'b1, 4'h3));
         settle(2);
         chk("irq_clr", 32'h0, {31'h0, irq_o});
      end
      mode_to(ctl(3'h0, 1'b0, 1'b0, 1'b1, 4'h2));
      u_far.set_base(16'h1000, 16'h0);
      pin(1'b1);
      pin(1'b0);
      rdc("per_1", 4'h0, {16'h0, ctl(3'h0, 1'b0, 1'b0, 1'b1, 4'h2)});
      u_far.set_base(16'h1400, 16'h0);
      pin(1'b1);
      rdc("per_coh", 4'hC, 32'h14001000);
      mode_to(ctl(3'h0, 1'b0, 1'b0, 1'b1, 4'h1));
      pin(1'b0);
      u_far.set_base(16'h2000, 16'h0);
      pin(1'b1);
      u_far.set_base(16'h2345, 16'h0);
      pin(1'b0);
      rdc("pw_coh", 4'hC, 32'h23452000);
      for (int m = 4; m < 6; m++)
      begin
         mode_to(ctl(3'h0, 1'b0, 1'b0, 1'b1, m[3:0]));
         u_far.set_base(16'h0300, 16'h0);
         wrw(4'h4, 16'h0300);
         settle(3);
         chk("pin_set", 32'h1, {31'h0, pin_o});
         rdc("flag_a", 4'h0, {16'h0, ctl(3'h0, 1'b0, 1'b0, 1'b1, m[3:0])
            | 16'h0080 | (m == 5 ? 16'h8000 : 16'h0000)});
         wrw(4'h8, 16'h0300);
         settle(3);
         chk("pin_clr", 32'h0, {31'h0, pin_o});
         rdc("flag_b", 4'h0, {16'h0, ctl(3'h0, 1'b0, 1'b0, 1'b1, m[3:0])
            | 16'h8000});
      end
      for (int i = 0; i < 8; i++)
      begin
         u_far.set_base(16'h0001, 16'h0);
         mode_to(ctl(3'h0, 1'b0, 1'b0, 1'b1, 4'(8 + i)));
         u_far.set_base(16'(1 << rw[i]), 16'h0);
         settle(3);
         acc(1'b0, 4'h0, 32'h0);
         chk("pwm_wrap", 32'h1, {31'h0, q[15]});
      end
      wrw(4'h4, 16'h0010);
      wrw(4'h8, 16'h0020);
      rdc("pwm_b1", 4'h8, 32'h0020);
      u_far.set_base(16'h0000, 16'h0);
      u_far.set_base(16'h0010, 16'h0);
      settle(3);
      chk("pwm_set", 32'h1, {31'h0, pin_o});
      u_far.set_base(16'h0020, 16'h0);
      settle(3);
      chk("pwm_clr", 32'h0, {31'h0, pin_o});
      // mid-run reset: pin released, data and control back to zero
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      settle(2);
      chk("rst_pin", 32'h0, {30'h0, pin_o, pin_oe_o});
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdc("rst_ctrl", 4'h0, 32'h0);
      rdc("rst_a", 4'h4, 32'h0);
      summarize();
   end
endmodule
